// file: design/tcsc_master.sv
/*
  Serial master for a bank of tunable capacitors: takes tuning commands
  at a plain user port and sends 8-bit telegrams over latch enable,
  serial clock and data lines that it generates itself from clk.
  Assumes commands come from logic on clk; the devices only listen.
  The serial clock is clk divided by eight: 20 ns high, 20 ns low.
  Phase counts are 4 bits; a faster clk needing over sixteen cycles
  per phase would overflow them.
  One command keeps the port busy for 81 clk cycles, accept to done;
  a request raised meanwhile is neither taken nor stored.
*/
// Notes on behaviour
// - Latch enable rises before any serial clock edge of a telegram.
// - Telegram bits leave most significant first, bit 0 last.
// - Data changes only while serial clock is low: first bit after the enable rises, the rest at falling edges; returns to zero as the enable falls.
// - Word is two reserved bits, standby bit 5, tuning state bits 4..0.
// - Reserved bits 7 and 6 are always sent as zero.
// - Each device has its own latch enable; only framed devices listen.
// - Separate enables program devices one after another.
// - Separate data lines with a shared enable update all at once.
// - Shared enable mode resends every device's word each update.
// - Latch enable leads first rising clock by at least 19.2 ns.
// - Latch enable falls at least 19.2 ns after last rising clock.
// - Enable low at least 38.4 ns; serial clock period at least 38.4 ns.
`timescale 1ns/10ps
`include "tcsc_cfg.svh"

module tcsc_master
  import tcsc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire tcsc_mode_t              cmd_mode,
  input  wire logic [`TCSC_DEV_W-1:0]  cmd_dev,
  input  wire logic                    cmd_standby,
  input  wire logic [`TCSC_TUNE_W-1:0] cmd_state,
  output logic                         done,
  output logic [`TCSC_NUM_DEV-1:0]     latch_enable,
  output logic                         serial_clk,
  output logic [`TCSC_NUM_DEV-1:0]     serial_data
);

  tcsc_state_t                 state;
  tcsc_state_t                 next_state;
  logic [3:0]                  cnt;
  logic [3:0]                  next_cnt;
  logic [2:0]                  ld_step;
  logic [2:0]                  bit_idx;
  logic [`TCSC_DEV_W-1:0]      tgt;
  tcsc_mode_t                  mode;
  tcsc_word_t                  shreg [`TCSC_NUM_DEV];
  tcsc_word_t                  mem_rdata;
  tcsc_word_t                  cmd_word;
  logic                        accept;
  logic                        load_done;
  logic                        setup_first;
  logic                        hi_end;
  logic                        do_shift;
  logic                        hold_end;
  logic                        gap_end;

  // Command word; reserved bits forced low so the user cannot set them
  assign cmd_word = {`TCSC_RSVD_VAL, cmd_standby, cmd_state};

  // A command is taken only while the sequencer is idle
  assign accept      = cmd_valid && cmd_ready;

  // Phase ends, decoded from the sequencer and its counter
  assign load_done   = (state == TCSC_ST_LOAD) && (ld_step == 3'(`TCSC_NUM_DEV));
  assign setup_first = (state == TCSC_ST_SETUP) && (cnt == 4'(`TCSC_ESU_CYC - 1));
  assign hi_end      = (state == TCSC_ST_HI) && (cnt == 4'h0);

  // No shift after the eighth rise, so bit 0 stays put through the hold
  assign do_shift    = hi_end && (bit_idx != 3'h7);

  // Back end of the frame: enable hold, then the enable low gap
  assign hold_end    = (state == TCSC_ST_HOLD) && (cnt == 4'h0);
  assign gap_end     = (state == TCSC_ST_GAP) && (cnt == 4'h0);

  // Every command lands in the shadow store, so a later shared-enable
  // update can resend unchanged devices without the user repeating them
  tcsc_word_mem u_mem (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (accept),
    .wr_addr (cmd_dev),
    .wr_data (cmd_word),
    .rd_addr (ld_step[`TCSC_DEV_W-1:0]),
    .rd_data (mem_rdata)
  );

  // Sequencer transitions and phase counter reloads
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      // Shadow store is written on the same edge that takes the command
      TCSC_ST_IDLE: begin
        if (accept) begin
          next_state = TCSC_ST_LOAD;
        end
      end
      // Four reads, one a cycle, then the frame opens
      TCSC_ST_LOAD: begin
        if (load_done) begin
          next_state = TCSC_ST_SETUP;
          next_cnt   = 4'(`TCSC_ESU_CYC - 1);
        end
      end
      // Enable already high; wait out the lead before the first rise
      TCSC_ST_SETUP: begin
        if (cnt == 4'h0) begin
          next_state = TCSC_ST_HI;
          next_cnt   = 4'(`TCSC_HALF_CYC - 1);
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      // High half of the serial clock; data must not move here
      TCSC_ST_HI: begin
        if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else if (bit_idx == 3'h7) begin
          // Hold counted from the fall, which is already a half period late
          next_state = TCSC_ST_HOLD;
          next_cnt   = 4'(`TCSC_EHD_CYC - 1);
        end else begin
          next_state = TCSC_ST_LO;
          next_cnt   = 4'(`TCSC_HALF_CYC - 1);
        end
      end
      // Low half; the next bit was put out at its start
      TCSC_ST_LO: begin
        if (cnt == 4'h0) begin
          next_state = TCSC_ST_HI;
          next_cnt   = 4'(`TCSC_HALF_CYC - 1);
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      // Clock low, bit 0 still on the line until the enable falls
      TCSC_ST_HOLD: begin
        if (cnt == 4'h0) begin
          next_state = TCSC_ST_GAP;
          next_cnt   = 4'(`TCSC_EOW_CYC - 1);
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      // Enable low; no new frame may open until this runs out
      TCSC_ST_GAP: begin
        if (cnt == 4'h0) begin
          next_state = TCSC_ST_IDLE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      // Codes that are not one-hot fall back to idle
      default: begin
        next_state = TCSC_ST_IDLE;
        next_cnt   = 4'h0;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TCSC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Phase counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Command capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt  <= '0;
      mode <= TCSC_MODE_SEQ;
    end else if (accept) begin
      tgt  <= cmd_dev;
      mode <= cmd_mode;
    end
  end

  // Load walk over the shadow store; read data lag the address by one,
  // so the walk runs one step past the last entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_step <= 3'h0;
    end else if (state == TCSC_ST_LOAD) begin
      ld_step <= ld_step + 3'h1;
    end else begin
      ld_step <= 3'h0;
    end
  end

  // Bit counter: a telegram is exactly eight clocks, never more
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_idx <= 3'h0;
    end else if (state == TCSC_ST_SETUP) begin
      bit_idx <= 3'h0;
    end else if (do_shift) begin
      bit_idx <= bit_idx + 3'h1;
    end
  end

  // Serial clock idles low and toggles only inside a frame
  // Both edges come from the phase counter, so high and low are exact
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_clk <= 1'h0;
    end else if ((state == TCSC_ST_SETUP || state == TCSC_ST_LO) && cnt == 4'h0) begin
      serial_clk <= 1'h1;
    end else if (hi_end) begin
      serial_clk <= 1'h0;
    end
  end

  // Per-device shift register, enable and data line
  genvar d;
  generate
    for (d = 0; d < `TCSC_NUM_DEV; d++) begin : g_dev
      tcsc_word_t src;

      // In sequential mode all data lines carry the target's word,
      // which matches a board where they are one shared wire
      assign src = (mode == TCSC_MODE_SIM) ? shreg[d] : shreg[tgt];

      // Filled from the shadow store in the load walk, then shifted left
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          shreg[d] <= `TCSC_WORD_RST;
        end else if (state == TCSC_ST_LOAD && ld_step == 3'(d + 1)) begin
          shreg[d] <= mem_rdata;
        end else if (do_shift) begin
          shreg[d] <= {shreg[d][`TCSC_WORD_W-2:0], 1'h0};
        end
      end

      // Data set up while the clock is low, moved at its fall, cleared as the enable falls
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          serial_data[d] <= 1'h0;
        end else if (setup_first) begin
          serial_data[d] <= src[`TCSC_WORD_W-1];
        end else if (do_shift) begin
          serial_data[d] <= src[`TCSC_WORD_W-2];
        end else if (hold_end) begin
          serial_data[d] <= 1'h0;
        end
      end

      // Only the target frames in sequential mode; all frame together
      // otherwise, so every device applies on the same falling edge
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          latch_enable[d] <= 1'h0;
        end else if (load_done) begin
          latch_enable[d] <= (mode == TCSC_MODE_SIM) || (tgt == `TCSC_DEV_W'(d));
        end else if (hold_end) begin
          latch_enable[d] <= 1'h0;
        end
      end
    end
  endgenerate

  // Ready again only after the enable low gap has run out
  // A request held while busy is dropped, never queued
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ready <= 1'h1;
    end else if (accept) begin
      cmd_ready <= 1'h0;
    end else if (gap_end) begin
      cmd_ready <= 1'h1;
    end
  end

  // Completion pulse, one cycle, with ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'h0;
    end else begin
      done <= gap_end;
    end
  end

endmodule

// file: include/tcsc_cfg.svh
/*
  Constants for the tunable capacitor serial controller: word layout,
  device count and link timing, all as macros.
  Assumes a 200 MHz system clock; times are kept in picoseconds.
*/
`ifndef TCSC_CFG_SVH
`define TCSC_CFG_SVH

// Fan-out of the controller
`define TCSC_NUM_DEV     4
`define TCSC_DEV_W       2

// Telegram layout
`define TCSC_WORD_W      8
`define TCSC_TUNE_W      5
`define TCSC_STBY_BIT    5
`define TCSC_RSVD_W      2
`define TCSC_RSVD_VAL    2'h0
`define TCSC_WORD_RST    8'h00

// System clock period
`define TCSC_CLK_PS      5000

// Link times as printed, in picoseconds
`define TCSC_T_SCL_PS    38400
`define TCSC_T_ESU_PS    19200
`define TCSC_T_EHD_PS    19200
`define TCSC_T_EOW_PS    38400

// Least times round up to whole clock cycles
`define TCSC_HALF_CYC ((`TCSC_T_SCL_PS + 2 * `TCSC_CLK_PS - 1) / (2 * `TCSC_CLK_PS))
`define TCSC_ESU_CYC  ((`TCSC_T_ESU_PS + `TCSC_CLK_PS - 1) / `TCSC_CLK_PS)
`define TCSC_EHD_CYC  ((`TCSC_T_EHD_PS + `TCSC_CLK_PS - 1) / `TCSC_CLK_PS)
`define TCSC_EOW_CYC  ((`TCSC_T_EOW_PS + `TCSC_CLK_PS - 1) / `TCSC_CLK_PS)

`endif

// file: include/tcsc_pkg.sv
/*
  Types for the tunable capacitor serial controller.
  Assumes tcsc_cfg.svh is reachable on the include path.
*/
`include "tcsc_cfg.svh"

package tcsc_pkg;

  typedef logic [`TCSC_WORD_W-1:0] tcsc_word_t;

  // Update style chosen per command
  typedef enum logic {
    TCSC_MODE_SEQ = 1'h0,
    TCSC_MODE_SIM = 1'h1
  } tcsc_mode_t;

  // Frame sequencer, one-hot
  typedef enum logic [6:0] {
    TCSC_ST_IDLE  = 7'h01,
    TCSC_ST_LOAD  = 7'h02,
    TCSC_ST_SETUP = 7'h04,
    TCSC_ST_HI    = 7'h08,
    TCSC_ST_LO    = 7'h10,
    TCSC_ST_HOLD  = 7'h20,
    TCSC_ST_GAP   = 7'h40
  } tcsc_state_t;

endpackage

// file: design/tcsc_word_mem.sv
/*
  Shadow store of the last word sent to each device, one entry per device.
  Assumes a single clock; read data appear one cycle after the address.
*/
`timescale 1ns/10ps
`include "tcsc_cfg.svh"

module tcsc_word_mem
  import tcsc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   wr_en,
  input  wire logic [`TCSC_DEV_W-1:0] wr_addr,
  input  wire tcsc_word_t             wr_data,
  input  wire logic [`TCSC_DEV_W-1:0] rd_addr,
  output tcsc_word_t                  rd_data
);

  tcsc_word_t entry [`TCSC_NUM_DEV];

  // One storage word per device
  genvar g;
  generate
    for (g = 0; g < `TCSC_NUM_DEV; g++) begin : g_entry
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          entry[g] <= `TCSC_WORD_RST;
        end else if (wr_en && (wr_addr == `TCSC_DEV_W'(g))) begin
          entry[g] <= wr_data;
        end
      end
    end
  endgenerate

  // Registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= `TCSC_WORD_RST;
    end else begin
      rd_data <= entry[rd_addr];
    end
  end

endmodule

// file: testbench/tcsc_dev_model.sv
/*
  Behavioural tunable capacitor: shifts telegrams in, applies on enable fall.
  Assumes one instance per latch enable and data line; no reset pin.
*/
`timescale 1ns/10ps
`include "tcsc_cfg.svh"

module tcsc_dev_model
  import tcsc_pkg::*;
(
  input  wire logic latch_enable,
  input  wire logic serial_clk,
  input  wire logic serial_data,
  output tcsc_word_t word,
  output logic       standby
);
  tcsc_word_t shifted;

  // No bit counter: older bits simply fall off the top
  always @(posedge serial_clk) begin
    if (latch_enable) begin
      shifted <= {shifted[`TCSC_WORD_W-2:0], serial_data};
    end
  end

  // Power-up word unknown until the first frame lands
  always @(negedge latch_enable) begin
    word <= shifted;
  end

  assign standby = word[`TCSC_STBY_BIT];
endmodule

// file: testbench/tcsc_master_checker.sv
/*
  Link timing and framing assertions for the serial master.
  Assumes it is bound to tcsc_master and sees only its ports.
*/
`timescale 1ns/10ps
`include "tcsc_cfg.svh"

module tcsc_master_checker
  import tcsc_pkg::*;
(
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire logic                     cmd_valid,
  input wire logic                     cmd_ready,
  input wire logic                     done,
  input wire logic [`TCSC_NUM_DEV-1:0] latch_enable,
  input wire logic                     serial_clk,
  input wire logic [`TCSC_NUM_DEV-1:0] serial_data
);
  logic       any_le;
  logic [3:0] rise_cnt;
  logic [7:0] since_rise;

  assign any_le = |latch_enable;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Rises per frame, cleared while nobody is framed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt <= 4'h0;
    end else if (!any_le) begin
      rise_cnt <= 4'h0;
    end else if ($rose(serial_clk)) begin
      rise_cnt <= rise_cnt + 4'h1;
    end
  end

  // Saturating age of the last rise; lags the wire by one edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_rise <= 8'hFF;
    end else if ($rose(serial_clk)) begin
      since_rise <= 8'h00;
    end else if (since_rise != 8'hFF) begin
      since_rise <= since_rise + 8'h01;
    end
  end

  sequence s_hi_pulse;
    serial_clk [*4] ##1 !serial_clk;
  endsequence
  sequence s_lo_gap;
    !serial_clk [*4];
  endsequence

  a_le_lead: assert property ($rose(any_le) |-> s_lo_gap)
    else $error("serial clock too close after enable rise");
  a_clk_high: assert property ($rose(serial_clk) |-> s_hi_pulse)
    else $error("serial clock high time wrong");
  a_clk_low: assert property ($fell(serial_clk) |-> s_lo_gap)
    else $error("serial clock low time too short");
  a_data_quiet: assert property ($changed(serial_data) |-> !serial_clk)
    else $error("data moved while serial clock high");
  a_le_hold: assert property ($fell(any_le) |-> since_rise >= `TCSC_EHD_CYC - 1)
    else $error("enable fell too soon after last rise");
  a_le_gap: assert property ($fell(any_le) |-> !any_le [*8])
    else $error("enable low time too short");
  a_eight_rises: assert property ($fell(any_le) |-> rise_cnt == 4'h8)
    else $error("frame did not carry eight bits");
  a_rsvd_zero: assert property ($rose(serial_clk) && rise_cnt < 4'h2 |->
    serial_data == 4'h0)
    else $error("reserved bit sent as one");
  a_done_lat: assert property (cmd_valid && cmd_ready |-> ##[81:82] done)
    else $error("done late or missing");
endmodule

bind tcsc_master tcsc_master_checker tcsc_master_checker_i (
  .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .done(done),
  .latch_enable(latch_enable), .serial_clk(serial_clk), .serial_data(serial_data)
);

// file: testbench/tcsc_master_test.sv
/*
  Self-checking bench: master drives four device models.
  Assumes the checker is bound in; inputs move 1 ns after clk rises.
*/
`timescale 1ns/10ps
`include "tcsc_cfg.svh"

module tcsc_master_test
  import tcsc_pkg::*;
;
  logic                    clk, rst_n, cmd_valid, cmd_ready, cmd_standby, done, serial_clk;
  tcsc_mode_t              cmd_mode;
  logic [`TCSC_DEV_W-1:0]  cmd_dev;
  logic [`TCSC_TUNE_W-1:0] cmd_state;
  logic [`TCSC_NUM_DEV-1:0] latch_enable, serial_data, dev_stby;
  tcsc_word_t              dev_word [`TCSC_NUM_DEV];
  tcsc_word_t              exp_word [`TCSC_NUM_DEV];
  int                      error_cnt, n_checks;

  tcsc_master tcsc_master_i (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_mode(cmd_mode), .cmd_dev(cmd_dev), .cmd_standby(cmd_standby),
    .cmd_state(cmd_state), .done(done), .latch_enable(latch_enable),
    .serial_clk(serial_clk), .serial_data(serial_data)
  );

  // One device per enable and data line
  for (genvar g = 0; g < `TCSC_NUM_DEV; g++) begin : g_dev
    tcsc_dev_model tcsc_dev_model_i (
      .latch_enable(latch_enable[g]), .serial_clk(serial_clk),
      .serial_data(serial_data[g]), .word(dev_word[g]), .standby(dev_stby[g])
    );
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check_word(input tcsc_word_t got, input tcsc_word_t exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_all();
    for (int i = 0; i < `TCSC_NUM_DEV; i++) check_word(dev_word[i], exp_word[i]);
  endtask

  // Holds the request until the edge that takes it
  task automatic issue(input tcsc_mode_t m, input int d, input logic s, input int st);
    int n;
    n = 0;
    cmd_mode = m;
    cmd_dev = d[`TCSC_DEV_W-1:0];
    cmd_standby = s;
    cmd_state = st[`TCSC_TUNE_W-1:0];
    cmd_valid = 1'b1;
    do @(posedge clk); while (cmd_ready !== 1'b1 && ++n < 200);
    check_word({7'h00, cmd_ready}, 8'h01);
    #1 cmd_valid = 1'b0;
    exp_word[d] = {`TCSC_RSVD_VAL, s, st[`TCSC_TUNE_W-1:0]};
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
    end while (done !== 1'b1 && ++n < 200);
    check_word({7'h00, done}, 8'h01);
  endtask

  task automatic t_reset();
    check_word({cmd_ready, 3'h0, latch_enable}, 8'h80);
    check_word({done, serial_clk, 2'h0, serial_data}, 8'h00);
  endtask

  // Shared enable rewrites unchanged devices with their stored words
  task automatic t_sim(input int d, input logic s, input int st);
    issue(TCSC_MODE_SIM, d, s, st);
    wait_done();
    check_all();
  endtask

  // Only the framed device moves; the others ignore the shared lines
  task automatic t_seq_each();
    int st [4] = '{0, 21, 10, 31};
    for (int d = 0; d < `TCSC_NUM_DEV; d++) begin
      issue(TCSC_MODE_SEQ, d, d[0], st[d]);
      wait_done();
      check_all();
      check_word({7'h00, dev_stby[d]}, {7'h00, d[0]});
    end
  endtask

  // A request raised while busy must leave no trace
  task automatic t_refuse();
    issue(TCSC_MODE_SEQ, 0, 1'b0, 7);
    @(posedge clk);
    #1 cmd_mode = TCSC_MODE_SIM;
    cmd_state = 5'h1F;
    cmd_valid = 1'b1;
    repeat (40) @(posedge clk);
    #1 check_word({7'h00, cmd_ready}, 8'h00);
    cmd_valid = 1'b0;
    wait_done();
    repeat (20) @(posedge clk);
    #1 check_all();
    check_word({4'h0, latch_enable}, 8'h00);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #50000;
    error_cnt++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_mode = TCSC_MODE_SEQ;
    cmd_dev = '0;
    cmd_standby = 1'b0;
    cmd_state = '0;
    error_cnt = 0;
    n_checks = 0;
    for (int i = 0; i < `TCSC_NUM_DEV; i++) exp_word[i] = `TCSC_WORD_RST;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_sim(1, 1'b0, 31);
    t_seq_each();
    t_sim(2, 1'b1, 3);
    t_refuse();
    t_sim(3, 1'b0, 12);
    stop_test();
  end
endmodule
